// ===== shared/sfec_pkg.sv
// sfec_pkg: opcodes, field positions, layout and timing constants for the erase block
// assumes byte-addressed array split into two equal dies
package sfec_pkg;

    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [7:0] OP_UNLOCK      = 8'h06;
    localparam logic [7:0] OP_SMALL       = 8'h20;
    localparam logic [7:0] OP_SMALL_LONG  = 8'h21;
    localparam logic [7:0] OP_LARGE       = 8'hD8;
    localparam logic [7:0] OP_LARGE_LONG  = 8'hDC;
    localparam logic [7:0] OP_DIE         = 8'hFE;

    // ****************************************
    // frame lengths in bits
    // ****************************************
    localparam logic [5:0] LEN_OP         = 6'h08;
    localparam logic [5:0] LEN_SHORT      = 6'h20;
    localparam logic [5:0] LEN_LONG       = 6'h28;
    localparam logic [5:0] LEN_SAT        = 6'h38;

    // ****************************************
    // array layout
    // ****************************************
    localparam int LARGE_PER_DIE = 256;
    localparam int SMALL_PER_DIE = 8;
    localparam int DIE_ALOG2     = 26;
    localparam int LARGE_ALOG2   = 18;
    localparam int OVL_ALOG2     = 15;
    localparam int SMALL_ALOG2   = 12;

    // ****************************************
    // status bits and timing
    // ****************************************
    localparam int         ST_BUSY    = 0;
    localparam int         ST_UNLOCK  = 1;
    localparam int         ST_FAIL    = 5;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam int         PREPROG_CYC = 16;
    localparam int         ERASE_CYC   = 32;

    typedef enum logic [3:0] {
        S_IDLE  = 4'h1,
        S_PRE   = 4'h2,
        S_ERASE = 4'h4,
        S_WALK  = 4'h8
    } sfec_state_e;

endpackage

// ===== core/sfec_link.sv
// sfec_link: serial-clock side shifter collecting opcode, address and bit count
// assumes sck only toggles inside frames; words stay stable after cs_n rises
`timescale 1ns/1ps
module sfec_link (
    input  wire logic        resetn,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic [3:0]  io_in,
    input  wire logic        quad_all_bit,
    output logic      [7:0]  opcode,
    output logic      [31:0] addr,
    output logic      [5:0]  bit_count
);

    typedef struct packed {
        logic        quad_s1;
        logic        quad_s2;
        logic [5:0]  cnt;
        logic [7:0]  op;
        logic [31:0] adr;
    } sfec_link_s;

    sfec_link_s q;
    sfec_link_s d;
    logic       open_q;

    // ****************************************
    // shifting
    // ****************************************
    always_comb begin
        logic [5:0] base;
        logic [5:0] step;
        base = open_q ? q.cnt : 6'h00;
        step = 6'h01;
        d = q;
        d.quad_s1 = quad_all_bit;
        d.quad_s2 = q.quad_s1;
        if (q.quad_s2) begin
            step = 6'h04; // [RULE1] [RULE23]
            if (base < sfec_pkg::LEN_OP) begin
                d.op = {q.op[3:0], io_in};
            end else begin
                d.adr = {q.adr[27:0], io_in};
            end
        end else begin
            if (base < sfec_pkg::LEN_OP) begin
                d.op = {q.op[6:0], io_in[0]};
            end else begin
                d.adr = {q.adr[30:0], io_in[0]}; // [RULE21]
            end
        end
        d.cnt = (base > sfec_pkg::LEN_SAT) ? base : 6'(base + step);
    end

    always_ff @(posedge sck or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // frame marker, cleared while cs_n is high
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            open_q <= 1'b0;
        end else begin
            open_q <= 1'b1;
        end
    end

    assign opcode    = q.op;
    assign addr      = q.adr;
    assign bit_count = q.cnt;

endmodule // sfec_link

// ===== core/sfec_core.sv
// sfec_core: erase command interpreter of a serial flash, clk domain plus sck link
// assumes config and lock ports are synchronous to clk; sck and cs_n come from pins
//
// How it works
// [RULE1] quad-all mode moves opcode and address four bits per serial clock
// [RULE2] small sectors overlay bottom of lowest or top of highest large sector
// [RULE3] uniform layout makes both small-block opcodes do nothing at all
// [RULE4] small-block wipe clears one addressed 4 KB sector to all ones
// [RULE5] any wipe needs the write-unlock latch set by an earlier command
// [RULE6] 20h address length follows long-address bit, 21h always four bytes
// [RULE7] D8h address length follows long-address bit, DCh always four bytes
// [RULE8] chip select must rise right after last address bit or nothing runs
// [RULE9] a valid wipe starts at chip-select rise: preprogram phase, then erase
// [RULE10] busy flag is one throughout the internal cycle, zero after
// [RULE11] small-block wipe of locked sector is refused and sets the fail flag
// [RULE12] small-block wipe outside small sectors is refused, fail flag unchanged
// [RULE13] large-block wipe of locked sector is refused and sets the fail flag
// [RULE14] hybrid layout: large wipe of overlaid sector spares the small ones
// [RULE15] uniform layout: every large wipe clears a whole 256 KB sector
// [RULE16] one persistent and one volatile lock bit per physical sector
// [RULE17] plain whole-array opcodes unsupported; die wipe with 4-byte address
// [RULE18] die wipe clears the selected die only, the other is untouched
// [RULE19] die wipe skipped without fail flag when range-lock bits are nonzero
// [RULE20] die wipe skips every locked sector without setting the fail flag
// [RULE21] die wipe address is four bytes, msb first, then chip select rises
// [RULE22] busy flag is bit 0 of the status byte
// [RULE23] quad-all bit high means four instruction bits per clock edge
// [RULE24] write-unlock latch clears when a wipe ends or is refused
// [RULE25] wrong address length for the opcode discards the command silently
`timescale 1ns/1ps
module sfec_core #(
    parameter int LARGE    = sfec_pkg::LARGE_PER_DIE,
    parameter int SMALL    = sfec_pkg::SMALL_PER_DIE,
    parameter int PRE_CYC  = sfec_pkg::PREPROG_CYC,
    parameter int ERS_CYC  = sfec_pkg::ERASE_CYC,
    parameter int LOC_N    = LARGE + SMALL,
    parameter int TOTAL    = 2 * LOC_N,
    parameter int IDX_W    = $clog2(TOTAL)
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             sck,
    input  wire logic             cs_n,
    input  wire logic [3:0]       io_in,
    input  wire logic             quad_all_bit,
    input  wire logic             long_address_bit,
    input  wire logic             uniform_layout_bit,
    input  wire logic             small_at_top,
    input  wire logic [2:0]       range_lock_bits,
    input  wire logic             lock_wr_en,
    input  wire logic             lock_wr_persist,
    input  wire logic             lock_wr_val,
    input  wire logic [IDX_W-1:0] lock_wr_idx,
    input  wire logic             wipe_fail_clear,
    output logic      [7:0]       status_one_volatile,
    output logic                  erase_strobe,
    output logic      [IDX_W-1:0] erase_sector,
    output logic                  erase_partial,
    output logic                  preprogram_active
);

    localparam int LOC_W = $clog2(LOC_N);
    localparam int LG_W  = sfec_pkg::DIE_ALOG2 - sfec_pkg::LARGE_ALOG2;
    localparam int LGP   = LG_W + 1;
    localparam int SM_W  = sfec_pkg::OVL_ALOG2 - sfec_pkg::SMALL_ALOG2;
    localparam int OV_W  = sfec_pkg::LARGE_ALOG2 - sfec_pkg::OVL_ALOG2;
    localparam int TMR_W = 16;

    typedef struct packed {
        logic                   cs1;
        logic                   cs2;
        logic                   cs3;
        sfec_pkg::sfec_state_e  st;
        logic [7:0]             status;
        logic [TMR_W-1:0]       timer;
        logic                   walk;
        logic                   die;
        logic [LOC_W-1:0]       widx;
        logic [IDX_W-1:0]       tgt;
        logic                   tgt_part;
        logic                   strobe;
        logic [IDX_W-1:0]       sector;
        logic                   part;
        logic                   pre;
        logic [TOTAL-1:0]       plock;
        logic [TOTAL-1:0]       vlock;
    } sfec_core_s;

    sfec_core_s q;
    sfec_core_s d;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [IDX_W-1:0] phys(input logic die, input logic [LOC_W-1:0] loc);
        return die ? IDX_W'(LOC_N + int'(loc)) : IDX_W'(loc);
    endfunction

    function automatic logic range_hit(input logic [2:0] bp, input logic [LG_W-1:0] big);
        logic [LGP-1:0] span;
        span = LGP'(1) << (bp - 3'h1);
        return (bp != 3'h0) && ({1'b0, big} >= LGP'(LARGE) - span);
    endfunction

    // ****************************************
    // serial clock side
    // ****************************************
    logic [7:0]  lk_op;
    logic [31:0] lk_adr;
    logic [5:0]  lk_cnt;

    sfec_link u_link (
        .resetn       (resetn),
        .sck          (sck),
        .cs_n         (cs_n),
        .io_in        (io_in),
        .quad_all_bit (quad_all_bit),
        .opcode       (lk_op),
        .addr         (lk_adr),
        .bit_count    (lk_cnt)
    );

    // ****************************************
    // command decode at frame end
    // ****************************************
    logic             rise;
    logic             idle;
    logic             need4;
    logic             len_ok;
    logic             is_small;
    logic             is_large;
    logic             is_die;
    logic             write_unlock_latch;
    logic [31:0]      a;
    logic             die_sel;
    logic [LG_W-1:0]  big;
    logic [LG_W-1:0]  ovl_big;
    logic             ovl_hit;
    logic             in_ovl;
    logic [IDX_W-1:0] small_ix;
    logic [IDX_W-1:0] big_ix;
    logic             small_lock;
    logic             big_lock;

    // words from the link are quiet once cs_n is high, so sampling after sync is safe
    assign rise     = q.cs2 & ~q.cs3; // [RULE9]
    assign idle     = (q.st == sfec_pkg::S_IDLE);
    assign is_small = (lk_op == sfec_pkg::OP_SMALL) | (lk_op == sfec_pkg::OP_SMALL_LONG);
    assign is_large = (lk_op == sfec_pkg::OP_LARGE) | (lk_op == sfec_pkg::OP_LARGE_LONG);
    assign is_die   = (lk_op == sfec_pkg::OP_DIE); // [RULE17]
    assign need4    = (lk_op == sfec_pkg::OP_SMALL_LONG) | (lk_op == sfec_pkg::OP_LARGE_LONG)
                    | is_die | long_address_bit; // [RULE6] [RULE7] [RULE21]
    assign len_ok   = lk_cnt == (need4 ? sfec_pkg::LEN_LONG : sfec_pkg::LEN_SHORT); // [RULE8]
    assign write_unlock_latch      = q.status[sfec_pkg::ST_UNLOCK];
    assign a        = need4 ? lk_adr : {8'h00, lk_adr[23:0]};
    assign die_sel  = a[sfec_pkg::DIE_ALOG2];
    assign big      = a[sfec_pkg::DIE_ALOG2-1:sfec_pkg::LARGE_ALOG2];
    assign ovl_big  = small_at_top ? LG_W'(LARGE - 1) : '0; // [RULE2]
    assign ovl_hit  = small_at_top ? (&a[sfec_pkg::LARGE_ALOG2-1:sfec_pkg::OVL_ALOG2])
                                   : ~(|a[sfec_pkg::LARGE_ALOG2-1:sfec_pkg::OVL_ALOG2]);
    assign in_ovl   = (big == ovl_big) && ovl_hit; // [RULE2]
    assign small_ix = phys(die_sel,
                           LOC_W'(LARGE + int'(a[sfec_pkg::OVL_ALOG2-1:sfec_pkg::SMALL_ALOG2])));
    assign big_ix   = phys(die_sel, LOC_W'(big));
    assign small_lock = range_hit(range_lock_bits, big) | q.plock[small_ix]
                      | q.vlock[small_ix]; // [RULE11] [RULE16]
    assign big_lock   = range_hit(range_lock_bits, big) | q.plock[big_ix]
                      | q.vlock[big_ix]; // [RULE13] [RULE16]

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        logic [IDX_W-1:0] wix;
        logic             wskip;
        wix   = phys(q.die, q.widx);
        wskip = q.plock[wix] | q.vlock[wix]
              | (uniform_layout_bit && (int'(q.widx) >= LARGE)); // [RULE20]
        d = q;
        d.cs1    = cs_n;
        d.cs2    = q.cs1;
        d.cs3    = q.cs2;
        d.strobe = 1'b0;
        if (lock_wr_en) begin
            if (lock_wr_persist) begin
                d.plock[lock_wr_idx] = lock_wr_val; // [RULE16]
            end else begin
                d.vlock[lock_wr_idx] = lock_wr_val; // [RULE16]
            end
        end
        if (wipe_fail_clear) begin
            d.status[sfec_pkg::ST_FAIL] = 1'b0;
        end
        case (q.st)
            sfec_pkg::S_IDLE: begin
                if (rise) begin
                    if (lk_op == sfec_pkg::OP_UNLOCK && lk_cnt == sfec_pkg::LEN_OP) begin
                        d.status[sfec_pkg::ST_UNLOCK] = 1'b1; // [RULE5]
                    end else if (is_small && !uniform_layout_bit && len_ok && write_unlock_latch) begin // [RULE3]
                        if (!in_ovl) begin
                            d.status[sfec_pkg::ST_UNLOCK] = 1'b0; // [RULE12] [RULE24]
                        end else if (small_lock) begin
                            d.status[sfec_pkg::ST_FAIL]   = 1'b1; // [RULE11]
                            d.status[sfec_pkg::ST_UNLOCK] = 1'b0; // [RULE24]
                        end else begin
                            d.st       = sfec_pkg::S_PRE; // [RULE4] [RULE9]
                            d.timer    = TMR_W'(PRE_CYC - 1);
                            d.walk     = 1'b0;
                            d.tgt      = small_ix;
                            d.tgt_part = 1'b0;
                            d.pre      = 1'b1;
                            d.status[sfec_pkg::ST_BUSY] = 1'b1; // [RULE10]
                        end
                    end else if (is_large && len_ok && write_unlock_latch) begin // [RULE5] [RULE7]
                        if (big_lock) begin
                            d.status[sfec_pkg::ST_FAIL]   = 1'b1; // [RULE13]
                            d.status[sfec_pkg::ST_UNLOCK] = 1'b0; // [RULE24]
                        end else begin
                            d.st       = sfec_pkg::S_PRE; // [RULE9]
                            d.timer    = TMR_W'(PRE_CYC - 1);
                            d.walk     = 1'b0;
                            d.tgt      = big_ix;
                            d.tgt_part = !uniform_layout_bit && (big == ovl_big); // [RULE14] [RULE15]
                            d.pre      = 1'b1;
                            d.status[sfec_pkg::ST_BUSY] = 1'b1; // [RULE10]
                        end
                    end else if (is_die && len_ok && write_unlock_latch) begin // [RULE17] [RULE21]
                        if (range_lock_bits != 3'h0) begin
                            d.status[sfec_pkg::ST_UNLOCK] = 1'b0; // [RULE19] [RULE24]
                        end else begin
                            d.st    = sfec_pkg::S_PRE; // [RULE9]
                            d.timer = TMR_W'(PRE_CYC - 1);
                            d.walk  = 1'b1;
                            d.die   = die_sel; // [RULE18]
                            d.widx  = '0;
                            d.pre   = 1'b1;
                            d.status[sfec_pkg::ST_BUSY] = 1'b1; // [RULE10]
                        end
                    end
                end
            end
            sfec_pkg::S_PRE: begin
                d.timer = q.timer - TMR_W'(1);
                if (q.timer == '0) begin
                    d.pre   = 1'b0; // [RULE9]
                    d.st    = q.walk ? sfec_pkg::S_WALK : sfec_pkg::S_ERASE;
                    d.timer = TMR_W'(ERS_CYC - 1);
                end
            end
            sfec_pkg::S_ERASE: begin
                d.timer = q.timer - TMR_W'(1);
                if (q.timer == '0) begin
                    d.strobe = 1'b1;
                    d.sector = q.tgt;
                    d.part   = q.tgt_part; // [RULE14]
                    d.st     = sfec_pkg::S_IDLE;
                    d.status[sfec_pkg::ST_BUSY]   = 1'b0; // [RULE10] [RULE22]
                    d.status[sfec_pkg::ST_UNLOCK] = 1'b0; // [RULE24]
                end
            end
            sfec_pkg::S_WALK: begin
                if (!wskip) begin
                    d.strobe = 1'b1; // [RULE18] [RULE20]
                    d.sector = wix;
                    d.part   = !uniform_layout_bit && (LG_W'(q.widx) == ovl_big)
                             && (int'(q.widx) < LARGE);
                end
                d.widx = q.widx + LOC_W'(1);
                if (int'(q.widx) == LOC_N - 1) begin
                    d.st = sfec_pkg::S_IDLE;
                    d.status[sfec_pkg::ST_BUSY]   = 1'b0; // [RULE10]
                    d.status[sfec_pkg::ST_UNLOCK] = 1'b0; // [RULE24]
                end
            end
            default: begin
                d.st = sfec_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q        <= '0;
            q.cs1    <= 1'b1;
            q.cs2    <= 1'b1;
            q.cs3    <= 1'b1;
            q.st     <= sfec_pkg::S_IDLE;
            q.status <= sfec_pkg::STATUS_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign status_one_volatile = q.status; // [RULE22]
    assign erase_strobe        = q.strobe;
    assign erase_sector        = q.sector;
    assign erase_partial       = q.part;
    assign preprogram_active   = q.pre;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_busy_tracks_run: assert property ( // [RULE10]
        (q.st == sfec_pkg::S_IDLE) == !q.status[sfec_pkg::ST_BUSY])
        else $error("busy flag disagrees with sequencer");

    a_uniform_ignore: assert property ( // [RULE3]
        (rise && idle && is_small && uniform_layout_bit && !wipe_fail_clear)
        |=> ($stable(q.status) && q.st == sfec_pkg::S_IDLE))
        else $error("small wipe acted under uniform layout");

    a_unlock_needed: assert property ( // [RULE5]
        (rise && idle && !write_unlock_latch) |=> (q.st == sfec_pkg::S_IDLE))
        else $error("wipe started without unlock latch");

    a_bad_length: assert property ( // [RULE25]
        (rise && idle && (is_small || is_large || is_die) && !len_ok && !wipe_fail_clear)
        |=> ($stable(q.status) && q.st == sfec_pkg::S_IDLE))
        else $error("wrong length frame changed state");

    a_start_preprog: assert property ( // [RULE9]
        (idle ##1 !idle) |-> (q.pre && q.st == sfec_pkg::S_PRE
                              && q.status[sfec_pkg::ST_BUSY]))
        else $error("wipe did not open with preprogram phase");

    a_small_locked: assert property ( // [RULE11]
        (rise && idle && is_small && !uniform_layout_bit && len_ok && write_unlock_latch && in_ovl
         && small_lock) |=> (q.status[sfec_pkg::ST_FAIL] && !q.status[sfec_pkg::ST_UNLOCK]))
        else $error("locked small wipe did not fail");

    a_small_outside: assert property ( // [RULE12]
        (rise && idle && is_small && !uniform_layout_bit && len_ok && write_unlock_latch && !in_ovl
         && !wipe_fail_clear) |=> ($stable(q.status[sfec_pkg::ST_FAIL])
                                   && q.st == sfec_pkg::S_IDLE && !write_unlock_latch))
        else $error("small wipe outside overlay misbehaved");

    a_large_locked: assert property ( // [RULE13]
        (rise && idle && is_large && len_ok && write_unlock_latch && big_lock)
        |=> (q.status[sfec_pkg::ST_FAIL] && q.st == sfec_pkg::S_IDLE))
        else $error("locked large wipe did not fail");

    a_partial_hybrid: assert property ( // [RULE15]
        q.strobe && q.part |-> !uniform_layout_bit)
        else $error("partial erase under uniform layout");

    a_die_range: assert property ( // [RULE19]
        (rise && idle && is_die && len_ok && write_unlock_latch && range_lock_bits != 3'h0 && !wipe_fail_clear)
        |=> ($stable(q.status[sfec_pkg::ST_FAIL]) && q.st == sfec_pkg::S_IDLE))
        else $error("die wipe ran under range lock");

    a_walk_scope: assert property ( // [RULE20]
        ($past(q.st == sfec_pkg::S_WALK) && q.strobe)
        |-> (!q.plock[q.sector] && !q.vlock[q.sector]
             && q.sector >= phys(q.die, '0) && q.sector <= phys(q.die, LOC_W'(LOC_N - 1))))
        else $error("die wipe touched locked or foreign sector");

endmodule // sfec_core

// ===== test/sfec_host.sv
// sfec_host: serial host model sending opcode and address frames
// assumes caller spaces frames; sck stands low between frames
`timescale 1ns/1ps
module sfec_host (
    output logic       sck,
    output logic       cs_n,
    output logic [3:0] io
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        io = 4'hA;
    end
    // ****************************************
    // frame sender, msb first, one or four lanes
    // ****************************************
    task automatic send(input logic [39:0] bits, input int n, input logic quad);
        int i;
        #13 cs_n = 1'b0;
        for (i = 0; i < n; i += (quad ? 4 : 1)) begin
            io = quad ? bits[39-i -: 4] : {~io[3:1], bits[39-i]};
            #20 sck = 1'b1;
            #40 sck = 1'b0;
            #20;
        end
        cs_n = 1'b1;
        io = ~io;
    endtask
endmodule // sfec_host

// ===== test/test_spi_flash_erase_commands.sv
// test_spi_flash_erase_commands: scenario bench for the erase interpreter
// assumes sfec_host drives the serial pins; config and locks driven here
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module test_spi_flash_erase_commands;
    logic clk = 1'b0, resetn, sck, cs_n, qa, la, uni, lwe, lwp, lwv, fclr, top;
    logic [3:0] io;
    logic [2:0] rl;
    logic [9:0] lwi, sec, last_sec, min_sec;
    logic [7:0] st;
    logic       stb, part, last_part, pre, saw_pre, saw_busy;
    int         n_fail = 0, n_compared = 0, n_stb;
    sfec_host host (.sck(sck), .cs_n(cs_n), .io(io));
    sfec_core #(.PRE_CYC(4), .ERS_CYC(4)) DUT (.clk(clk), .resetn(resetn), .sck(sck),
        .cs_n(cs_n), .io_in(io), .quad_all_bit(qa), .long_address_bit(la),
        .uniform_layout_bit(uni), .small_at_top(top), .range_lock_bits(rl),
        .lock_wr_en(lwe), .lock_wr_persist(lwp), .lock_wr_val(lwv), .lock_wr_idx(lwi),
        .wipe_fail_clear(fclr), .status_one_volatile(st), .erase_strobe(stb),
        .erase_sector(sec), .erase_partial(part), .preprogram_active(pre));
    always #20 clk = ~clk;
    always @(negedge clk) begin
        if (pre) saw_pre = 1'b1;
        if (stb) begin
            n_stb++;
            last_sec = sec;
            last_part = part;
            if (sec < min_sec) min_sec = sec;
        end
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic run(input logic [7:0] op, input logic [31:0] a, input int nb, input int lim);
        int k;
        n_stb = 0; saw_busy = 1'b0; saw_pre = 1'b0; min_sec = 10'h3FF;
        host.send(nb == 24 ? {op, a[23:0], 8'h00} : {op, a}, 8 + nb, qa);
        for (k = 0; k < lim; k++) begin
            @(negedge clk);
            if (st[0] === 1'b1) saw_busy = 1'b1;
            else if (saw_busy) break;
        end
        repeat (4) @(negedge clk);
    endtask
    task automatic unlock;
        host.send({8'h06, 32'h0}, 8, qa);
        repeat (6) @(negedge clk);
        `CHK("latch set", 1'b1, st[1])
    endtask
    task automatic lock(input logic p, input logic v, input logic [9:0] i);
        lwp = p; lwv = v; lwi = i; lwe = 1'b1;
        @(negedge clk);
        lwe = 1'b0;
        @(negedge clk);
    endtask
    task automatic expect_idle(input logic latch);
        `CHK("no busy", 1'b0, saw_busy)
        `CHK("latch", latch, st[1])
        `CHK("fail", 1'b0, st[5])
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_small;
        unlock();
        run(8'h20, 32'h0000_3000, 24, 60);
        `CHK("busy", 1'b1, saw_busy)
        `CHK("preprog", 1'b1, saw_pre)
        `CHK("sector", 10'h103, last_sec)
        `CHK("busy end", 1'b0, st[0])
        `CHK("latch end", 1'b0, st[1])
        `CHK("fail end", 1'b0, st[5])
        run(8'h20, 32'h0, 24, 12);
        expect_idle(1'b0);
        uni = 1'b1; unlock(); run(8'h21, 32'h0, 32, 12);
        expect_idle(1'b1);
        uni = 1'b0; run(8'h20, 32'h0004_0000, 24, 12);
        expect_idle(1'b0);
        unlock(); run(8'h20, 32'h0, 32, 12);
        expect_idle(1'b1);
        $display("test small done");
    endtask
    task automatic t_locks;
        lock(1'b0, 1'b1, 10'h000);
        run(8'hD8, 32'h0, 24, 12);
        `CHK("fail large", 1'b1, st[5])
        fclr = 1'b1; @(negedge clk); fclr = 1'b0; @(negedge clk);
        `CHK("fail clr", 1'b0, st[5])
        lock(1'b0, 1'b0, 10'h000); lock(1'b1, 1'b1, 10'h102);
        unlock(); run(8'h20, 32'h0000_2000, 24, 12);
        `CHK("fail small", 1'b1, st[5])
        `CHK("latch", 1'b0, st[1])
        fclr = 1'b1; @(negedge clk); fclr = 1'b0; lock(1'b1, 1'b0, 10'h102);
        $display("test locks done");
    endtask
    task automatic t_large;
        la = 1'b1; unlock(); run(8'hD8, 32'h0, 32, 60);
        `CHK("sector", 10'h000, last_sec)
        `CHK("partial", 1'b1, last_part)
        uni = 1'b1; unlock(); run(8'hDC, 32'h0, 32, 60);
        `CHK("strobes", 1, n_stb)
        `CHK("partial", 1'b0, last_part)
        qa = 1'b1; host.send(40'h0, 40, 1'b1); repeat (6) @(negedge clk);
        unlock(); run(8'hDC, 32'h0008_0000, 32, 60);
        `CHK("quad sector", 10'h002, last_sec)
        qa = 1'b0; host.send(40'h0, 40, 1'b1); repeat (6) @(negedge clk);
        uni = 1'b0; la = 1'b0;
        top = 1'b1; unlock(); run(8'h21, 32'h03FF_F000, 32, 60);
        `CHK("top sector", 10'h107, last_sec)
        top = 1'b0;
        $display("test large done");
    endtask
    task automatic t_die;
        unlock(); run(8'h60, 32'h0, 0, 12); run(8'hC7, 32'h0, 0, 12);
        expect_idle(1'b1);
        rl = 3'h1; run(8'hFE, 32'h0400_0000, 32, 12);
        expect_idle(1'b0);
        rl = 3'h0; lock(1'b0, 1'b1, 10'h10D); unlock();
        run(8'hFE, 32'h0400_0000, 32, 400);
        `CHK("strobes", 263, n_stb)
        `CHK("first", 10'h108, min_sec)
        `CHK("last", 10'h20F, last_sec)
        `CHK("fail", 1'b0, st[5])
        $display("test die done");
    endtask
    task automatic final_report;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #1000000;
        n_fail++;
        final_report();
    end
    initial begin
        {resetn, qa, la, uni, lwe, lwp, lwv, fclr, top, rl, lwi} = '0;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        `CHK("status rst", 8'h00, st)
        t_small(); t_locks(); t_large(); t_die();
        final_report();
    end
endmodule // test_spi_flash_erase_commands
